// [core/fwp_host.sv]
// Behaviour
// - hold low address bits fifteen ns
// - byte selects driven, never tied
// - wait one ms before first access
// - keep sleep low at least one us
// - sleep waits for hold and precharge after last write
// - wait 450 us after wakeup
`timescale 1ns/100ps
`default_nettype none
module fwp_host
	import fwp_pkg::*;
#(
	parameter int PU_CYCLES   = PU_CYC,
	parameter int ZZEX_CYCLES = ZZEX_CYC
) (
	// ----------------------------------------
	// clock and reset
	// ----------------------------------------
	input  wire logic              CLOCK_IN,
	input  wire logic              RESET_N_IN,
	// ----------------------------------------
	// user request
	// ----------------------------------------
	input  wire logic              REQ_VALID_IN,
	output logic                   REQ_READY_OUT,
	input  wire logic              REQ_WRITE_IN,
	input  wire logic [ADDR_W-1:0] REQ_ADDR_IN,
	input  wire logic [DATA_W-1:0] REQ_WDATA_IN,
	input  wire logic [1:0]        REQ_BYTE_EN_IN,
	input  wire logic              SLEEP_REQ_IN,
	// ----------------------------------------
	// user answer
	// ----------------------------------------
	output logic                   RSP_VALID_OUT,
	output logic [DATA_W-1:0]      RSP_RDATA_OUT,
	output logic                   ASLEEP_OUT,
	// ----------------------------------------
	// memory pins
	// ----------------------------------------
	output logic                   CHIP_EN_N_OUT,
	output logic                   WRITE_EN_N_OUT,
	output logic                   OUT_EN_N_OUT,
	output logic                   UPPER_BYTE_SELECT_N_OUT,
	output logic                   LOWER_BYTE_SELECT_N_OUT,
	output logic                   SLEEP_REQUEST_N_OUT,
	output logic [ADDR_W-1:0]      ADDR_OUT,
	output logic [DATA_W-1:0]      DQ_OUT,
	output logic                   DQ_OE_OUT,
	input  wire logic [DATA_W-1:0] DQ_IN
);

	fwp_state_t        state_r;
	logic [CNT_W-1:0]  cnt_r;
	logic              wr_r;
	logic              page_r;
	logic [DATA_W-1:0] dq_s1_r;
	logic [DATA_W-1:0] dq_s2_r;

	function automatic logic [CNT_W-1:0] cyc(input int n);
		cyc = CNT_W'(n - 1);
	endfunction

	// ----------------------------------------
	// pin input synchroniser
	// ----------------------------------------
	always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			dq_s1_r <= 16'h0000;
			dq_s2_r <= 16'h0000;
		end else begin
			dq_s1_r <= DQ_IN;
			dq_s2_r <= dq_s1_r;
		end
	end

	// a page access keeps upper address and CE low
	wire same_page = (REQ_ADDR_IN[ADDR_W-1:2] == ADDR_OUT[ADDR_W-1:2]);
	wire last_cnt = (cnt_r == '0);

	assign REQ_READY_OUT = (state_r == ST_IDLE) && !SLEEP_REQ_IN
		|| (state_r == ST_HOLD) && last_cnt && !SLEEP_REQ_IN && REQ_VALID_IN && same_page;
	assign ASLEEP_OUT = (state_r == ST_SLEEP);

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			state_r <= ST_POWERUP;
			cnt_r   <= '0;
			wr_r    <= 1'b0;
			page_r  <= 1'b0;
		end else begin
			if (!last_cnt)
				cnt_r <= cnt_r - 1'b1;
			case (state_r)
				ST_POWERUP: begin
					if (cnt_r == '0 && !page_r) begin
						cnt_r  <= cyc(PU_CYCLES);
						page_r <= 1'b1;
					end else if (last_cnt) begin
						page_r  <= 1'b0;
						state_r <= ST_IDLE;
					end
				end
				ST_IDLE: begin
					if (SLEEP_REQ_IN) begin
						cnt_r   <= cyc(ZZL_CYC);
						state_r <= ST_SLEEP;
					end else if (REQ_VALID_IN) begin
						wr_r    <= REQ_WRITE_IN;
						// WE falls one cycle in, so a write needs one count more
						cnt_r   <= cyc(REQ_WRITE_IN ? WP_CYC + 1 : AA_CYC);
						state_r <= ST_ACCESS;
					end
				end
				ST_ACCESS: begin
					if (last_cnt) begin
						// low address bits stay put at least this long
						cnt_r   <= cyc(PAGE_CYC > CA_CYC - WP_CYC ? PAGE_CYC : CA_CYC - WP_CYC);
						state_r <= ST_HOLD;
					end
				end
				ST_HOLD: begin
					if (last_cnt) begin
						if (REQ_READY_OUT && REQ_VALID_IN) begin
							wr_r    <= REQ_WRITE_IN;
							cnt_r   <= cyc(REQ_WRITE_IN ? WP_CYC + 1 : AA_CYC);
							state_r <= ST_ACCESS;
						end else begin
							cnt_r   <= cyc(PC_CYC);
							state_r <= ST_PRECHG;
						end
					end
				end
				ST_PRECHG: begin
					if (last_cnt)
						state_r <= ST_IDLE;
				end
				ST_SLEEP: begin
					if (last_cnt && !SLEEP_REQ_IN) begin
						cnt_r   <= cyc(ZZEX_CYCLES);
						state_r <= ST_WAKE;
					end
				end
				ST_WAKE: begin
					if (last_cnt)
						state_r <= ST_IDLE;
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// address, data, byte selects
	// ----------------------------------------
	always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			ADDR_OUT                <= 16'h0000;
			DQ_OUT                  <= 16'h0000;
			UPPER_BYTE_SELECT_N_OUT <= 1'b1;
			LOWER_BYTE_SELECT_N_OUT <= 1'b1;
		end else if (REQ_READY_OUT && REQ_VALID_IN) begin
			ADDR_OUT                <= REQ_ADDR_IN;
			DQ_OUT                  <= REQ_WDATA_IN;
			UPPER_BYTE_SELECT_N_OUT <= !REQ_BYTE_EN_IN[1];
			LOWER_BYTE_SELECT_N_OUT <= !REQ_BYTE_EN_IN[0];
		end
	end

	// ----------------------------------------
	// control pins
	// ----------------------------------------
	always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			CHIP_EN_N_OUT       <= 1'b1;
			WRITE_EN_N_OUT      <= 1'b1;
			OUT_EN_N_OUT        <= 1'b1;
			DQ_OE_OUT           <= 1'b0;
			SLEEP_REQUEST_N_OUT <= 1'b1;
		end else begin
			SLEEP_REQUEST_N_OUT <= !(state_r == ST_SLEEP || state_r == ST_IDLE && SLEEP_REQ_IN);
			if (REQ_READY_OUT && REQ_VALID_IN) begin
				CHIP_EN_N_OUT  <= 1'b0;
				// WE falls one cycle after address settles
				WRITE_EN_N_OUT <= 1'b1;
				OUT_EN_N_OUT   <= REQ_WRITE_IN;
				DQ_OE_OUT      <= REQ_WRITE_IN;
			end else if (state_r == ST_ACCESS) begin
				WRITE_EN_N_OUT <= !(wr_r && !last_cnt);
			end else if (state_r == ST_HOLD && last_cnt) begin
				CHIP_EN_N_OUT <= 1'b1;
				OUT_EN_N_OUT  <= 1'b1;
				DQ_OE_OUT     <= 1'b0;
			end else if (state_r == ST_HOLD) begin
				WRITE_EN_N_OUT <= 1'b1;
			end else if (state_r == ST_SLEEP) begin
				CHIP_EN_N_OUT <= 1'b1;
				DQ_OE_OUT     <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// read answer
	// ----------------------------------------
	always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			RSP_VALID_OUT <= 1'b0;
			RSP_RDATA_OUT <= 16'h0000;
		end else begin
			RSP_VALID_OUT <= (state_r == ST_ACCESS) && last_cnt;
			if (state_r == ST_ACCESS && last_cnt && !wr_r)
				RSP_RDATA_OUT <= dq_s2_r;
		end
	end

endmodule // fwp_host
`default_nettype wire

// [core/fwp_pkg.sv]
package fwp_pkg;
	// ----------------------------------------
	// widths
	// ----------------------------------------
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int CLK_PERIOD_NS = 10;
	// ----------------------------------------
	// timing, in their own units
	// ----------------------------------------
	localparam int T_PU_MS = 1;
	localparam int T_ZZL_US = 1;
	localparam int T_ZZEX_US = 450;
	localparam int T_PAGE_HOLD_NS = 15;
	localparam int T_CA_NS = 70;
	localparam int T_PC_NS = 35;
	localparam int T_WP_NS = 22;
	localparam int T_AA_NS = 70;
	// ----------------------------------------
	// derived cycle counts (least times round up)
	// ----------------------------------------
	localparam int PU_CYC = (T_PU_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ZZL_CYC = (T_ZZL_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ZZEX_CYC = (T_ZZEX_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PAGE_CYC = (T_PAGE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CA_CYC = (T_CA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PC_CYC = (T_PC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int AA_CYC = (T_AA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 20;
	// ----------------------------------------
	// states
	// ----------------------------------------
	typedef enum logic [6:0] {
		ST_POWERUP = 7'h01,
		ST_IDLE    = 7'h02,
		ST_ACCESS  = 7'h04,
		ST_HOLD    = 7'h08,
		ST_PRECHG  = 7'h10,
		ST_SLEEP   = 7'h20,
		ST_WAKE    = 7'h40
	} fwp_state_t;
endpackage

// [dv/fwp_host_asserts.sv]
`timescale 1ns/100ps
`default_nettype none
module fwp_host_asserts
	import fwp_pkg::*;
#(
	parameter int PU_CYCLES   = 20,
	parameter int ZZEX_CYCLES = 20
) (
	input wire logic              CLOCK_IN, RESET_N_IN, REQ_VALID_IN, REQ_READY_OUT, CHIP_EN_N_OUT,
	input wire logic              WRITE_EN_N_OUT, OUT_EN_N_OUT, UPPER_BYTE_SELECT_N_OUT,
	input wire logic              LOWER_BYTE_SELECT_N_OUT, SLEEP_REQUEST_N_OUT, DQ_OE_OUT,
	input wire logic [1:0]        REQ_BYTE_EN_IN,
	input wire logic [ADDR_W-1:0] REQ_ADDR_IN, ADDR_OUT
);
	int pu_r, wk_r, slp_cnt_r;
	default clocking @(posedge CLOCK_IN); endclocking
	default disable iff (!RESET_N_IN);
	always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
		if (!RESET_N_IN) begin
			pu_r <= 0;
			wk_r <= ZZEX_CYCLES;
			slp_cnt_r <= 0;
		end else begin
			pu_r <= pu_r + int'(pu_r < PU_CYCLES);
			wk_r <= SLEEP_REQUEST_N_OUT ? wk_r + int'(wk_r < ZZEX_CYCLES) : 0;
			slp_cnt_r <= SLEEP_REQUEST_N_OUT ? 0 : slp_cnt_r + 1;
		end
	end
	sequence take_s; REQ_VALID_IN && REQ_READY_OUT; endsequence
	sequence prechg_s; CHIP_EN_N_OUT[*4]; endsequence
	take_pins_a: assert property (take_s |=> ADDR_OUT == $past(REQ_ADDR_IN) &&
		{UPPER_BYTE_SELECT_N_OUT, LOWER_BYTE_SELECT_N_OUT} == ~$past(REQ_BYTE_EN_IN)) else $error("pins off");
	we_ce_a: assert property (!WRITE_EN_N_OUT |-> !CHIP_EN_N_OUT && DQ_OE_OUT) else $error("we");
	rd_float_a: assert property (!OUT_EN_N_OUT |-> !DQ_OE_OUT) else $error("drive in read");
	wr_hold_a: assert property ($fell(WRITE_EN_N_OUT) |-> ($stable(ADDR_OUT) && !CHIP_EN_N_OUT)[*2])
		else $error("write addr");
	prechg_a: assert property ($rose(CHIP_EN_N_OUT) |-> prechg_s) else $error("precharge");
	slp_float_a: assert property (!SLEEP_REQUEST_N_OUT |-> !DQ_OE_OUT && WRITE_EN_N_OUT) else $error("slp");
	slp_len_a: assert property ($rose(SLEEP_REQUEST_N_OUT) |-> slp_cnt_r >= ZZL_CYC) else $error("sleep short");
	first_acc_a: assert property ($fell(CHIP_EN_N_OUT) |-> pu_r >= PU_CYCLES && wk_r >= ZZEX_CYCLES)
		else $error("early access");
endmodule // fwp_host_asserts
bind fwp_host fwp_host_asserts #(.PU_CYCLES(PU_CYCLES), .ZZEX_CYCLES(ZZEX_CYCLES)) chk (.CLOCK_IN, .RESET_N_IN,
	.REQ_VALID_IN, .REQ_READY_OUT, .CHIP_EN_N_OUT, .WRITE_EN_N_OUT, .OUT_EN_N_OUT, .UPPER_BYTE_SELECT_N_OUT,
	.LOWER_BYTE_SELECT_N_OUT, .SLEEP_REQUEST_N_OUT, .DQ_OE_OUT, .REQ_BYTE_EN_IN, .REQ_ADDR_IN, .ADDR_OUT);
`default_nettype wire

// [dv/fwp_host_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module fwp_host_tb
	import fwp_pkg::*;
;
	logic clk = 0, rst_n = 0, v = 0, w = 0, slp = 0;
	logic [15:0] a = 0, d = 0, pg;
	logic [1:0] be = 0;
	wire logic rdy, rv, asl, ce_n, we_n, oe_n, upper_n, lower_n, sleep_n, dqoe;
	wire logic [15:0] rdata, ao, dqo, dqi, md;
	wire logic [1:0] drv;
	logic [15:0] ref_m [logic [15:0]];
	int num_errors = 0, tests_run = 0, cyc = 0, i;
	// released lanes read back inverted
	assign dqi = dqoe ? dqo : {drv[1] ? md[15:8] : ~md[15:8], drv[0] ? md[7:0] : ~md[7:0]};
	fwp_host #(.PU_CYCLES(20), .ZZEX_CYCLES(20)) uut (.CLOCK_IN(clk), .RESET_N_IN(rst_n), .REQ_VALID_IN(v),
		.REQ_READY_OUT(rdy), .REQ_WRITE_IN(w), .REQ_ADDR_IN(a), .REQ_WDATA_IN(d), .REQ_BYTE_EN_IN(be),
		.SLEEP_REQ_IN(slp), .RSP_VALID_OUT(rv), .RSP_RDATA_OUT(rdata), .ASLEEP_OUT(asl), .CHIP_EN_N_OUT(ce_n),
		.WRITE_EN_N_OUT(we_n), .OUT_EN_N_OUT(oe_n), .UPPER_BYTE_SELECT_N_OUT(upper_n),
		.LOWER_BYTE_SELECT_N_OUT(lower_n), .SLEEP_REQUEST_N_OUT(sleep_n), .ADDR_OUT(ao), .DQ_OUT(dqo),
		.DQ_OE_OUT(dqoe), .DQ_IN(dqi));
	fwp_mem_model mem (.ce_n_in(ce_n), .we_n_in(we_n), .oe_n_in(oe_n), .upper_byte_select_n_in(upper_n),
		.lower_byte_select_n_in(lower_n), .sleep_request_n_in(sleep_n), .addr_in(ao), .din_in(dqo),
		.dout_out(md), .drv_out(drv));
	task automatic print_verdict;
		if (num_errors == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, e, m);
		tests_run++;
		if ((g & m) !== (e & m)) begin
			num_errors++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic acc(input logic wr, input logic [15:0] ad, dt, input logic [1:0] en);
		int n;
		logic [15:0] m;
		m = {{8{en[1]}}, {8{en[0]}}};
		v <= 1;
		w <= wr;
		a <= ad;
		d <= dt;
		be <= en;
		n = 0;
		// ready is settled by mid-cycle and holds to the taking edge
		do @(negedge clk); while (rdy !== 1'b1 && ++n < 300);
		@(posedge clk);
		#1 v <= 0;
		n = 0;
		do begin @(posedge clk); #1 n++; end while (rv !== 1'b1 && n < 40);
		chk({15'h0, rv}, 16'h1, 16'h1);
		if (wr) ref_m[ad] = (ref_m[ad] & ~m) | (dt & m);
		else chk(rdata, ref_m[ad], m);
	endtask
	initial forever #5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			num_errors++;
			print_verdict;
		end
	end
	initial begin
		void'($urandom(32'hCF66B679));
		repeat (6) @(posedge clk);
		#1 rst_n <= 1;
		pg = 16'($urandom) & 16'hFFF8;
		for (i = 0; i < 8; i++) acc(1'h1, pg + 16'(i), 16'($urandom), 2'h3);
		for (i = 0; i < 40; i++) acc(1'($urandom), pg + 16'(3'($urandom)), 16'($urandom), 2'($urandom));
		slp <= 1;
		i = 0;
		while (asl !== 1'b1 && i < 50) begin @(posedge clk); #1 i++; end
		chk({15'h0, asl}, 16'h1, 16'h1);
		repeat (120) begin
			chk({15'h0, sleep_n}, 16'h0, 16'h1);
			chk({15'h0, rdy}, 16'h0, 16'h1);
			@(posedge clk);
			#1;
		end
		slp <= 0;
		acc(1'h0, pg, 16'h0, 2'h3);
		print_verdict;
	end
endmodule // fwp_host_tb
`default_nettype wire

// [dv/fwp_mem_model.sv]
`timescale 1ns/100ps
`default_nettype none
module fwp_mem_model
	import fwp_pkg::*;
(
	// ----------------------------------------
	// control pins
	// ----------------------------------------
	input  wire logic              ce_n_in,
	input  wire logic              we_n_in,
	input  wire logic              oe_n_in,
	input  wire logic              upper_byte_select_n_in,
	input  wire logic              lower_byte_select_n_in,
	input  wire logic              sleep_request_n_in,
	// ----------------------------------------
	// address and data
	// ----------------------------------------
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic [DATA_W-1:0] din_in,
	output logic      [DATA_W-1:0] dout_out,
	output logic      [1:0]        drv_out
);
	logic [DATA_W-1:0] mem_r [0:2**ADDR_W-1];
	wire logic wr_act = !ce_n_in && !we_n_in && sleep_request_n_in;
	// latch on whichever enable rises first
	always @(negedge wr_act) begin
		if (!upper_byte_select_n_in) mem_r[addr_in][15:8] = din_in[15:8];
		if (!lower_byte_select_n_in) mem_r[addr_in][7:0] = din_in[7:0];
	end
	assign dout_out = mem_r[addr_in];
	assign drv_out = (!ce_n_in && we_n_in && !oe_n_in && sleep_request_n_in) ?
		{!upper_byte_select_n_in, !lower_byte_select_n_in} : 2'h0;
endmodule // fwp_mem_model
`default_nettype wire
